// file: src/bzc_decode.sv
`timescale 1ns/10ps
`include "bzc_params.svh"
// Summary of operation
// - Branch-on-zero redirects only when zero flag is 1, else falls through.
// - Signed branch field is doubled to form byte displacement 2n.
// - Branch target is instruction address plus 2 plus 2n.
// - Branches take one word; one cycle not taken, two cycles taken.
// - Taken branch writes PC in Q4 then a nop cycle; not taken writes nothing.
// - Call accepts 20-bit unsigned word target k and save bit s.
// - Call pushes its address plus 4 onto the return stack.
// - Call loads k into PC bits 20 to 1, bit 0 cleared.
// - With s set, call copies working, flags and bank select into shadows.
// - First call word is 1110 110s with k bits 7 to 0 low.
// - Second call word is prefix 1111 with k bits 19 to 8.
// - With s clear, call leaves shadow registers unchanged.
// - Call takes exactly two cycles, the second all no-operation phases.
module bzc_decode
  import bzc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] instr_word,
  input wire logic [20:0] pc_current,
  input wire logic zero_flag,
  input wire logic overflow_flag,
  input wire logic [7:0] working_reg,
  input wire logic [7:0] flags_reg,
  input wire logic [7:0] bank_select_register,
  output logic [1:0] phase,
  output logic pc_write,
  output logic [20:0] pc_next,
  output logic stack_push,
  output logic [20:0] return_stack_top,
  output logic [7:0] working_shadow,
  output logic [7:0] flags_shadow,
  output logic [7:0] bank_select_shadow,
  output logic nop_cycle,
  output logic flags_write,
  output logic bad_call_word
);

  bzc_phase_t phase_ff;
  bzc_mode_t mode_ff;
  bzc_mode_t nxt_mode;
  logic [20:0] pc_next_ff;
  logic pc_write_ff;
  logic push_ff;
  logic [20:0] tos_ff;
  logic [7:0] ws_ff;
  logic [7:0] fs_ff;
  logic [7:0] bs_ff;
  logic [7:0] klow_ff;
  logic bad_ff;
  logic is_zero_op;
  logic is_ovf_op;
  logic is_call_op;
  logic take;

  // Sign-extends the branch field and doubles it into a byte offset
  function automatic logic [20:0] bzc_disp(input logic [7:0] n);
    bzc_disp = {{12{n[7]}}, n, 1'b0};
  endfunction

  // Opcode decoding, only meaningful in an executing cycle
  assign is_zero_op = (mode_ff == BZC_EXEC) && (instr_word[15:8] == `BZC_OP_ZERO);
  assign is_ovf_op = (mode_ff == BZC_EXEC) && (instr_word[15:8] == `BZC_OP_OVF);
  assign is_call_op = (mode_ff == BZC_EXEC) && (instr_word[15:9] == `BZC_OP_CALL7);
  assign take = (is_zero_op && zero_flag) || (is_ovf_op && overflow_flag);

  // Phase counter Q1..Q4
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= BZC_Q1;
    end else begin
      phase_ff <= bzc_phase_t'(phase_ff + 2'd1);
    end
  end

  // Next cycle kind, decided at Q4
  always_comb begin
    nxt_mode = mode_ff;
    if (phase_ff == BZC_Q4) begin
      unique case (mode_ff)
        BZC_EXEC: begin
          if (take) begin
            nxt_mode = BZC_NOP;
          end else if (is_call_op) begin
            nxt_mode = BZC_CALL2;
          end else begin
            nxt_mode = BZC_EXEC;
          end
        end
        BZC_NOP: nxt_mode = BZC_EXEC;
        BZC_CALL2: nxt_mode = BZC_EXEC;
        default: nxt_mode = BZC_EXEC;
      endcase
    end
  end

  // Cycle kind register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= BZC_EXEC;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Call first word capture: low target byte, held until the second word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      klow_ff <= `BZC_BYTE_RST;
    end else if (is_call_op && phase_ff == BZC_Q2) begin
      klow_ff <= instr_word[7:0];
    end
  end

  // Program counter write: branch in Q4 of exec cycle, call in Q4 of second word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc_write_ff <= 1'b0;
      pc_next_ff <= `BZC_PC_RST;
    end else begin
      pc_write_ff <= 1'b0;
      if (phase_ff == BZC_Q3 && take) begin
        pc_write_ff <= 1'b1;
        pc_next_ff <= pc_current + `BZC_PC_STEP + bzc_disp(instr_word[7:0]);
      end else if (phase_ff == BZC_Q3 && mode_ff == BZC_CALL2) begin
        pc_write_ff <= 1'b1;
        pc_next_ff <= {instr_word[11:0], klow_ff, 1'b0};
      end
    end
  end

  // Flags a second call word lacking the 1111 prefix
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bad_ff <= 1'b0;
    end else if (phase_ff == BZC_Q3 && mode_ff == BZC_CALL2) begin
      bad_ff <= (instr_word[15:12] != `BZC_PFX_CALL2);
    end
  end

  // Return stack push in Q3 of the first call word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      push_ff <= 1'b0;
      tos_ff <= `BZC_PC_RST;
    end else begin
      push_ff <= 1'b0;
      if (is_call_op && phase_ff == BZC_Q2) begin
        push_ff <= 1'b1;
        tos_ff <= pc_current + `BZC_CALL_RET;
      end
    end
  end

  // Shadow copies, only when the save option is set
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ws_ff <= `BZC_BYTE_RST;
      fs_ff <= `BZC_BYTE_RST;
      bs_ff <= `BZC_BYTE_RST;
    end else if (is_call_op && phase_ff == BZC_Q2 && instr_word[`BZC_SAVE_BIT]) begin
      ws_ff <= working_reg;
      fs_ff <= flags_reg;
      bs_ff <= bank_select_register;
    end
  end

  // Outputs
  assign phase = phase_ff;
  assign pc_write = pc_write_ff;
  assign pc_next = pc_next_ff;
  assign stack_push = push_ff;
  assign return_stack_top = tos_ff;
  assign working_shadow = ws_ff;
  assign flags_shadow = fs_ff;
  assign bank_select_shadow = bs_ff;
  assign nop_cycle = (mode_ff != BZC_EXEC);
  assign flags_write = 1'b0;
  assign bad_call_word = bad_ff;

  sequence s_taken_q3;
    phase_ff == BZC_Q3 && take;
  endsequence

  sequence s_write_then_nop;
    pc_write_ff ##1 (mode_ff == BZC_NOP) [*4];
  endsequence

  AST_TAKEN_WRITE: assert property (@(posedge clock) disable iff (!rstn)
    s_taken_q3 |=> s_write_then_nop) else $error("Taken branch did not write PC then idle");
  AST_TARGET: assert property (@(posedge clock) disable iff (!rstn)
    s_taken_q3 |=> pc_next_ff == $past(pc_current) + `BZC_PC_STEP + {{12{$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0})
    else $error("Branch target wrong");
  AST_ZERO_ONLY: assert property (@(posedge clock) disable iff (!rstn)
    (phase_ff == BZC_Q3 && is_zero_op && !zero_flag) |=> !pc_write_ff) else $error("Untaken zero branch wrote PC");
  AST_NOTTAKEN_NOWRITE: assert property (@(posedge clock) disable iff (!rstn)
    (phase_ff == BZC_Q3 && (is_zero_op || is_ovf_op) && !take) |=> !pc_write_ff)
    else $error("Untaken branch wrote PC");
  AST_NOTTAKEN_1CYC: assert property (@(posedge clock) disable iff (!rstn)
    (phase_ff == BZC_Q4 && (is_zero_op || is_ovf_op) && !take) |=> mode_ff == BZC_EXEC)
    else $error("Untaken branch took extra cycle");
  AST_PUSH: assert property (@(posedge clock) disable iff (!rstn)
    (is_call_op && phase_ff == BZC_Q2) |=> push_ff && tos_ff == $past(pc_current) + `BZC_CALL_RET)
    else $error("Call return address wrong");
  AST_CALL_PC: assert property (@(posedge clock) disable iff (!rstn)
    (phase_ff == BZC_Q3 && mode_ff == BZC_CALL2) |=> pc_write_ff && pc_next_ff[0] == 1'b0 &&
      pc_next_ff[8:1] == klow_ff) else $error("Call target wrong");
  AST_CALL_2CYC: assert property (@(posedge clock) disable iff (!rstn)
    (is_call_op && phase_ff == BZC_Q4) |=> (mode_ff == BZC_CALL2) [*4] ##1 mode_ff == BZC_EXEC)
    else $error("Call did not last two cycles");
  AST_NO_SAVE: assert property (@(posedge clock) disable iff (!rstn)
    (is_call_op && phase_ff == BZC_Q2 && !instr_word[8]) |=> $stable(ws_ff) && $stable(fs_ff) && $stable(bs_ff))
    else $error("Shadows changed without save");
  AST_SAVE: assert property (@(posedge clock) disable iff (!rstn)
    (is_call_op && phase_ff == BZC_Q2 && instr_word[8]) |=> ws_ff == $past(working_reg) &&
      fs_ff == $past(flags_reg) && bs_ff == $past(bank_select_register)) else $error("Shadow copy missing");
  AST_NO_FLAGS: assert property (@(posedge clock) disable iff (!rstn)
    !flags_write) else $error("Flags written");

endmodule

// file: src/bzc_params.svh
`ifndef BZC_PARAMS_SVH
`define BZC_PARAMS_SVH
// Opcode upper bytes and second-word prefix
`define BZC_OP_ZERO 8'he0
`define BZC_OP_OVF 8'he4
`define BZC_OP_CALL7 7'h76
`define BZC_PFX_CALL2 4'hf
// Field positions in the instruction word
`define BZC_SAVE_BIT 8
// Byte increments of the program counter
`define BZC_PC_STEP 21'h00_0002
`define BZC_CALL_RET 21'h00_0004
// Reset values
`define BZC_PC_RST 21'h00_0000
`define BZC_BYTE_RST 8'h00
`endif

// file: src/bzc_pkg.sv
package bzc_pkg;
  // Instruction phases within one instruction cycle
  typedef enum logic [1:0] {
    BZC_Q1 = 2'b00,
    BZC_Q2 = 2'b01,
    BZC_Q3 = 2'b10,
    BZC_Q4 = 2'b11
  } bzc_phase_t;
  // Cycle kind: normal execution or a forced no-operation cycle
  typedef enum logic [1:0] {
    BZC_EXEC = 2'b00,
    BZC_NOP = 2'b01,
    BZC_CALL2 = 2'b10
  } bzc_mode_t;
endpackage

// file: tb/bzc_decode_tb.sv
`timescale 1ns/10ps
module tb;
  import bzc_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [20:0] pc_current = 21'h00_0000;
  logic zero_flag = 1'b0;
  logic overflow_flag = 1'b0;
  logic [7:0] working_reg = 8'h00;
  logic [7:0] flags_reg = 8'h00;
  logic [7:0] bank_select_register = 8'h00;
  logic nop_exp = 1'b0;
  wire logic [1:0] phase;
  wire logic pc_write, stack_push, nop_cycle, flags_write, bad_call_word;
  wire logic [20:0] pc_next, return_stack_top;
  wire logic [7:0] working_shadow, flags_shadow, bank_select_shadow;
  logic [20:0] pc_q[$], tos_q[$];
  logic [23:0] shd_q[$];
  logic bad_q[$];
  logic [23:0] shd_got;
  logic [1:0] ph_cnt = 2'b00;
  int fails = 0;
  int checks = 0;
  int i;
  logic [7:0] op, n;
  logic [19:0] k;
  logic [20:0] pcv;
  logic [23:0] shd_m = 24'h00_0000;
  logic [23:0] rv;
  bzc_decode dut_u (.clock(clock), .rstn(rstn), .instr_word(instr_word), .pc_current(pc_current),
    .zero_flag(zero_flag), .overflow_flag(overflow_flag), .working_reg(working_reg), .flags_reg(flags_reg),
    .bank_select_register(bank_select_register), .phase(phase), .pc_write(pc_write), .pc_next(pc_next),
    .stack_push(stack_push), .return_stack_top(return_stack_top), .working_shadow(working_shadow),
    .flags_shadow(flags_shadow), .bank_select_shadow(bank_select_shadow), .nop_cycle(nop_cycle),
    .flags_write(flags_write), .bad_call_word(bad_call_word));
  // Clock at 100 MHz
  always #5 clock = ~clock;
  // Verdict and end of run
  task automatic wrap_up();
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Address results
  task automatic chk_addr(input logic [20:0] got, input logic [20:0] exp);
    checks++;
    if (got !== exp || $isunknown(got)) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Level and byte results
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp || $isunknown(got)) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One instruction, with its second cycle when it has one
  task automatic issue(input logic [15:0] w1, input logic [15:0] w2, input logic two);
    instr_word <= w1;
    nop_exp <= 1'b0;
    repeat (4) @(posedge clock);
    if (two) begin
      instr_word <= w2;
      nop_exp <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask
  // Output watcher, settled just after each edge
  always @(posedge clock) begin
    #1;
    if (rstn) begin
      chk_val(24'(phase), 24'(ph_cnt));
      ph_cnt = ph_cnt + 2'b01;
      chk_val(24'(flags_write), 24'h00_0000);
      chk_val(24'(nop_cycle), 24'(nop_exp));
      if (pc_write === 1'b1) begin
        chk_addr(pc_next, (pc_q.size() > 0) ? pc_q.pop_front() : ~pc_next);
        if (nop_cycle === 1'b1) begin
          chk_val(24'(bad_call_word), (bad_q.size() > 0) ? 24'(bad_q.pop_front()) : ~24'(bad_call_word));
        end
      end
      if (stack_push === 1'b1) begin
        chk_addr(return_stack_top, (tos_q.size() > 0) ? tos_q.pop_front() : ~return_stack_top);
        shd_got = {working_shadow, flags_shadow, bank_select_shadow};
        chk_val(shd_got, (shd_q.size() > 0) ? shd_q.pop_front() : ~shd_got);
      end
    end
  end
  // Hang guard
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  // Mixed stream of branches and calls, boundary fields first
  initial begin
    rv = 24'($urandom(96016));
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    for (i = 0; i < 40; i++) begin
      pcv = 21'($urandom()) & 21'h1f_fffe;
      pc_current <= pcv;
      zero_flag <= i[1];
      overflow_flag <= i[2];
      rv = 24'($urandom());
      working_reg <= rv[23:16];
      flags_reg <= rv[15:8];
      bank_select_register <= rv[7:0];
      if (i % 4 == 3) begin
        k = (i < 8) ? 20'h0_0000 : (i < 16) ? 20'hf_ffff : 20'($urandom());
        pc_q.push_back({k, 1'b0});
        tos_q.push_back(pcv + 21'h00_0004);
        if (i[3]) shd_m = rv;
        shd_q.push_back(shd_m);
        bad_q.push_back(i == 35);
        issue({7'h76, i[3], k[7:0]}, {(i == 35) ? 4'he : 4'hf, k[19:8]}, 1'b1);
      end else begin
        op = i[0] ? 8'he4 : 8'he0;
        n = (i < 12) ? 8'h80 : (i < 24) ? 8'h7f : 8'($urandom());
        if (i[0] ? i[2] : i[1]) pc_q.push_back(pcv + 21'h00_0002 + {{12{n[7]}}, n, 1'b0});
        issue({op, n}, 16'h0000, i[0] ? i[2] : i[1]);
      end
    end
    issue(16'h0000, 16'h0000, 1'b0);
    chk_val(24'(pc_q.size() + tos_q.size() + shd_q.size() + bad_q.size()), 24'h00_0000);
    wrap_up();
  end
endmodule
